// *** hdl/phone_mcu_interrupt_unit.sv ***
// Vectored five-source interrupt controller with Avalon-MM register access
`timescale 1ns/100ps

// Overview of operation
// [RULE1] Taking an interrupt clears the global enable bit in hardware.
// [RULE2] Blocked requests still set their flags but cause no vectoring.
// [RULE3] A full return stack blocks every acknowledge until it is popped.
// [RULE4] Only the program counter is pushed on entry.
// [RULE5] Falling edge on external pin sets its flag; vector 04H.
// [RULE6] Vector only with source enable, global enable, stack room, flag set.
// [RULE7] Vectoring clears the source flag and global enable together.
// [RULE8] Timer A overflow sets its flag; vector 08H.
// [RULE9] Timer B overflow sets its flag; vector 0CH.
// [RULE10] Each 1Hz clock tick sets the clock flag; vector 14H.
// [RULE11] Hook any edge, hold fall, hands-free rise set line flag; vector 18H.
// [RULE12] Hold fall ignored while on-hook and holding the line.
// [RULE13] Line interrupt disabled while the operating mode is Idle.
// [RULE14] Return-from-interrupt sets global enable; plain return leaves it.
// [RULE15] Software may re-enable inside a handler to nest, if stack has room.
// [RULE16] Requests between two sample pulses are serviced at the later pulse.
// [RULE17] Fixed priority: external, timer A, timer B, clock, line.
// [RULE18] Any source can wake the controller from halted states.
// [RULE19] Primary register bits 0 to 3 are global, ext, timer A, timer B enables.
// [RULE20] Primary bits 4 to 6 are request flags, bit 7 reads zero.
// [RULE21] Secondary: bit1 clock en, bit2 line en, bit5/6 flags, bits 3/7 zero.
// [RULE22] Flags stay set until serviced or cleared by software.
// [RULE23] Vector and push request go to the program counter in one cycle.
module phone_mcu_interrupt_unit
    import irq_unit_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Sources
    input  wire logic        ext_irq_pin_b,
    input  wire logic        timer_a_overflow,
    input  wire logic        timer_b_overflow,
    input  wire logic        clock_tick,
    input  wire logic        hook_switch_input,
    input  wire logic        hold_input,
    input  wire logic        handsfree_input,
    input  wire logic        dialer_on_hook,
    input  wire logic        dialer_hold_line,
    input  wire logic [1:0]  operating_mode,
    // Core handshake
    input  wire logic        sample_phase_pulse,
    input  wire logic        stack_full,
    input  wire logic        return_from_irq_instr,
    input  wire logic        plain_return_instr,
    output logic             pc_push_req,
    output logic [7:0]       vector_addr,
    output logic             wake_req
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_last_q;
    logic [1:0] arm_q;
    logic       pins_valid_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= 4'hF;
            pin_sync_q <= 4'hF;
        end else begin
            pin_meta_q <= {handsfree_input, hold_input, hook_switch_input, ext_irq_pin_b};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Edge history is armed only once the history flop holds a synchronised
    // pin value; arming earlier lets the all-ones reset value of the chain
    // fake an edge on the external, hook or hold pin when it idles low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_last_q   <= 4'hF;
            arm_q        <= 2'h0;
            pins_valid_q <= 1'b0;
        end else begin
            pin_last_q   <= pin_sync_q;
            arm_q        <= {arm_q[0], 1'b1};
            pins_valid_q <= arm_q[1];
        end
    end

    wire ext_fall   = pins_valid_q & pin_last_q[0] & ~pin_sync_q[0]; // RULE5
    wire hook_edge  = pins_valid_q & (pin_last_q[1] ^ pin_sync_q[1]);
    wire hold_fall  = pins_valid_q & pin_last_q[2] & ~pin_sync_q[2];
    wire hf_rise    = pins_valid_q & ~pin_last_q[3] & pin_sync_q[3];
    wire hold_block = dialer_on_hook & dialer_hold_line;                 // RULE12
    wire line_idle  = (operating_mode == MODE_IDLE);                     // RULE13
    wire line_event = ~line_idle & (hook_edge | (hold_fall & ~hold_block) | hf_rise); // RULE11

    wire [NUM_SRC-1:0] src_event = {line_event, clock_tick,          // RULE10
                                    timer_b_overflow, timer_a_overflow, // RULE8 RULE9
                                    ext_fall};

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    logic        rd_done_q;
    logic        global_en_q;
    logic [NUM_SRC-1:0] src_en_q;
    logic [NUM_SRC-1:0] flag_q;
    logic [1:0]  rsvd_q;

    // Reads take one wait cycle so read data comes from a flop
    assign avs_waitrequest = avs_read & ~rd_done_q;

    wire sel_pri  = (avs_address == ADDR_CTRL_PRI);
    wire sel_sec  = (avs_address == ADDR_CTRL_SEC);
    wire wr_pri   = avs_write & sel_pri & avs_byteenable[0];
    wire wr_sec   = avs_write & sel_sec & avs_byteenable[0];
    wire [7:0] wd = avs_writedata[7:0];

    wire [7:0] pri_view = {1'b0, flag_q[2], flag_q[1], flag_q[0],
                           src_en_q[2], src_en_q[1], src_en_q[0], global_en_q}; // RULE19 RULE20
    wire [7:0] sec_view = {1'b0, flag_q[4], flag_q[3], rsvd_q[1],
                           1'b0, src_en_q[4], src_en_q[3], rsvd_q[0]};          // RULE21
    wire [7:0] rd_mux   = sel_pri ? pri_view : (sel_sec ? sec_view : 8'h00);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_done_q    <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_done_q <= avs_read & ~rd_done_q;
            if (avs_read & ~rd_done_q) begin
                avs_readdata <= {24'h000000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // Sampling window and priority selection
    // ------------------------------------------------------------
    take_state_t state_q;
    take_state_t state_d;

    // Fixed priority: lowest index wins
    function automatic logic [NUM_SRC-1:0] pick_first(input logic [NUM_SRC-1:0] req);
        logic [NUM_SRC-1:0] res;
        res = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                res = '0;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

    wire [NUM_SRC-1:0] eligible = flag_q & src_en_q;                        // RULE6
    wire               can_take = global_en_q & ~stack_full;               // RULE3 RULE15
    wire [NUM_SRC-1:0] winner   = pick_first(eligible);                    // RULE17
    wire               take     = (state_q == ST_WATCH) & sample_phase_pulse
                                  & can_take & (|eligible);                 // RULE16

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_WATCH: begin
                if (take) begin
                    state_d = ST_TAKE;
                end
            end
            ST_TAKE: begin
                state_d = ST_WATCH;
            end
            default: begin
                state_d = ST_WATCH;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_WATCH;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Flags and enables
    // ------------------------------------------------------------
    wire [NUM_SRC-1:0] sw_wr_mask = {{2{wr_sec}}, {3{wr_pri}}};
    wire [NUM_SRC-1:0] sw_wr_flag = {wd[BIT_LINE_FL], wd[BIT_CLOCK_FL], wd[BIT_TIMER_B_FL],
                                     wd[BIT_TIMER_A_FL], wd[BIT_EXT_FLAG]};
    wire [NUM_SRC-1:0] sw_wr_en   = {wd[BIT_LINE_EN], wd[BIT_CLOCK_EN], wd[BIT_TIMER_B_EN],
                                     wd[BIT_TIMER_A_EN], wd[BIT_EXT_EN]};
    wire [NUM_SRC-1:0] svc_clr    = take ? winner : '0;                      // RULE7

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            // Hardware set beats a clear in the same cycle
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    flag_q[g] <= 1'b0;
                end else if (src_event[g]) begin
                    flag_q[g] <= 1'b1;                                       // RULE2
                end else if (svc_clr[g]) begin
                    flag_q[g] <= 1'b0;
                end else if (sw_wr_mask[g]) begin
                    flag_q[g] <= sw_wr_flag[g];                              // RULE22
                end
            end
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    src_en_q[g] <= 1'b0;
                end else if (sw_wr_mask[g]) begin
                    src_en_q[g] <= sw_wr_en[g];
                end
            end
        end
    endgenerate

    // Hardware clear on entry wins over a simultaneous software write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_en_q <= 1'b0;
        end else if (take) begin
            global_en_q <= 1'b0;                                             // RULE1
        end else if (return_from_irq_instr) begin
            global_en_q <= 1'b1;                                             // RULE14
        end else if (wr_pri) begin
            global_en_q <= wd[BIT_GLOBAL_EN];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsvd_q <= 2'b00;
        end else if (wr_sec) begin
            rsvd_q <= {wd[BIT_RSVD_HI], wd[BIT_RSVD_LO]};
        end
    end

    // ------------------------------------------------------------
    // Core handshake
    // ------------------------------------------------------------
    wire [7:0] vec_sel = winner[0] ? VEC_EXT :
                         winner[1] ? VEC_TIMER_A :
                         winner[2] ? VEC_TIMER_B :
                         winner[3] ? VEC_CLOCK : VEC_LINE;

    // Only the return address is stacked; the core saves nothing else
    assign pc_push_req = take;                                               // RULE4 RULE23
    assign vector_addr = vec_sel;                                            // RULE23
    assign wake_req    = |(flag_q & src_en_q);                               // RULE18

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_entry_clears_global: assert property (pc_push_req |=> !global_en_q) // RULE1
        else $error("global enable not cleared on entry");
    a_blocked_no_vector: assert property (!global_en_q |-> !pc_push_req) // RULE2
        else $error("vectored while blocked");
    a_full_stack_block: assert property (stack_full |-> !pc_push_req) // RULE3
        else $error("vectored with full stack");
    a_take_on_pulse: assert property (pc_push_req |-> sample_phase_pulse) // RULE16
        else $error("vectored outside a sample pulse");
    a_ext_vector_top: assert property (pc_push_req && flag_q[0] && src_en_q[0] // RULE17
                                       |-> vector_addr == VEC_EXT)
        else $error("external source lost priority");
    a_line_vector_val: assert property (pc_push_req && (eligible == 5'b10000) // RULE11
                                        |-> vector_addr == VEC_LINE)
        else $error("wrong line vector");
    a_flag_clr_entry: assert property (pc_push_req && winner[1] && !src_event[1] // RULE7
                                       |=> !flag_q[1])
        else $error("timer flag not cleared on entry");
    a_irq_return_global: assert property (return_from_irq_instr && !pc_push_req // RULE14
                                          |=> global_en_q)
        else $error("return did not re-enable");
    a_timer_flag_set: assert property (timer_a_overflow |=> flag_q[1]) // RULE8
        else $error("timer flag not set");
    // Checked at the flag, so a leak through any path other than a software write still shows
    a_idle_no_line: assert property (line_idle && !flag_q[4] && !wr_sec // RULE13
                                     |=> !flag_q[4])
        else $error("line flag set in idle");
    a_flag_holds: assert property (flag_q[3] && !svc_clr[3] && !wr_sec |=> flag_q[3]) // RULE22
        else $error("clock flag dropped");

    // A plain return leaves the global enable exactly where it was
    a_plain_return_keeps: assert property (plain_return_instr && !return_from_irq_instr // RULE14
                                           && !take && !wr_pri
                                           |=> global_en_q == $past(global_en_q))
        else $error("plain return changed global enable");
    a_push_one_cycle: assert property (pc_push_req |=> !pc_push_req) // RULE1
        else $error("push request held for two cycles");
    a_blocked_flag_set: assert property (!global_en_q && timer_b_overflow |=> flag_q[2]) // RULE2
        else $error("blocked request lost its flag");
    a_ext_flag_set: assert property (ext_fall |=> flag_q[0]) // RULE5
        else $error("external fall did not set its flag");
    a_clock_flag_set: assert property (clock_tick |=> flag_q[3]) // RULE10
        else $error("clock tick did not set its flag");
    a_hook_flag_set: assert property (hook_edge && !line_idle |=> flag_q[4]) // RULE11
        else $error("hook edge did not set the line flag");
    a_hold_fall_masked: assert property (hold_fall && hold_block && !hook_edge // RULE12
                                         && !hf_rise && !flag_q[4] && !wr_sec |=> !flag_q[4])
        else $error("masked hold fall set the line flag");
    a_sw_flag_clear: assert property (wr_pri && !wd[BIT_TIMER_A_FL] && !src_event[1] // RULE22
                                      |=> !flag_q[1])
        else $error("software clear of timer flag lost");
    a_wake_on_event: assert property (timer_b_overflow && src_en_q[2] && !wr_pri // RULE18
                                      |=> wake_req)
        else $error("enabled request did not ask for wake-up");
    a_timer_b_vector: assert property (pc_push_req && winner[2] // RULE9
                                       |-> vector_addr == VEC_TIMER_B)
        else $error("wrong timer B vector");
    a_vector_needs_en: assert property (pc_push_req // RULE6
                                        |-> global_en_q && (|(flag_q & src_en_q)))
        else $error("vectored without enable and flag");
    // Read data is checked at the edge that completes the transfer
    a_read_top_zero: assert property (avs_read && !avs_waitrequest // RULE20
                                      |-> avs_readdata[31:7] == 25'h0)
        else $error("unused read bits not zero");
    a_sec_bit3_zero: assert property (avs_read && !avs_waitrequest && sel_sec // RULE21
                                      |-> !avs_readdata[3])
        else $error("secondary bit 3 not zero");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_take_ext: cover property (pc_push_req && winner[0]);
    c_take_line: cover property (pc_push_req && winner[4]);
    c_two_pending: cover property (pc_push_req && $countones(eligible) > 1);
    c_nest: cover property (pc_push_req ##[1:20] pc_push_req);
    c_full_stack_wait: cover property (sample_phase_pulse && global_en_q && stack_full && (|eligible));

endmodule

// *** hdl/irq_unit_pkg.sv ***
// Package: register map, field positions and vectors of the interrupt unit
package irq_unit_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_PRI = 8'h0B;
    localparam logic [7:0] IDX_CTRL_SEC = 8'h1E;
    localparam logic [9:0] ADDR_CTRL_PRI = {IDX_CTRL_PRI, 2'b00};
    localparam logic [9:0] ADDR_CTRL_SEC = {IDX_CTRL_SEC, 2'b00};
    // Primary register fields
    localparam int BIT_GLOBAL_EN  = 0;
    localparam int BIT_EXT_EN     = 1;
    localparam int BIT_TIMER_A_EN = 2;
    localparam int BIT_TIMER_B_EN = 3;
    localparam int BIT_EXT_FLAG   = 4;
    localparam int BIT_TIMER_A_FL = 5;
    localparam int BIT_TIMER_B_FL = 6;
    // Secondary register fields
    localparam int BIT_RSVD_LO    = 0;
    localparam int BIT_CLOCK_EN   = 1;
    localparam int BIT_LINE_EN    = 2;
    localparam int BIT_RSVD_HI    = 4;
    localparam int BIT_CLOCK_FL   = 5;
    localparam int BIT_LINE_FL    = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Sources in priority order, index 0 highest
    localparam int NUM_SRC = 5;
    localparam logic [7:0] VEC_EXT     = 8'h04;
    localparam logic [7:0] VEC_TIMER_A = 8'h08;
    localparam logic [7:0] VEC_TIMER_B = 8'h0C;
    localparam logic [7:0] VEC_CLOCK   = 8'h14;
    localparam logic [7:0] VEC_LINE    = 8'h18;
    localparam logic [1:0] MODE_IDLE   = 2'h1;
    typedef enum logic [1:0] {
        ST_WATCH = 2'b00,
        ST_TAKE  = 2'b01
    } take_state_t;
endpackage

// *** verification/core_model.sv ***
// Stand-in for the processor core: return stack, sample phase and return pulses
`timescale 1ns/100ps
module core_model #(
    parameter int DEPTH = 2
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       pc_push_req,
    input  wire logic [7:0] vector_addr,
    input  wire logic       pop_cmd,
    input  wire logic       pop_from_irq,
    output logic            sample_phase_pulse,
    output logic            stack_full,
    output logic            return_from_irq_instr,
    output logic            plain_return_instr,
    output logic [7:0]      push_count,
    output logic [7:0]      last_vec
);
    logic [1:0] phase_q;
    logic [3:0] depth_q;

    // ----------------------------------------------------------------
    // Phase pulse, stack state and return decode
    // ----------------------------------------------------------------
    assign sample_phase_pulse    = (phase_q == 2'h3);
    assign stack_full            = (depth_q == 4'(DEPTH));
    // Returns on an empty stack are dropped, as a real core would underflow
    assign return_from_irq_instr = pop_cmd & pop_from_irq & (depth_q != 4'h0);
    assign plain_return_instr    = pop_cmd & ~pop_from_irq & (depth_q != 4'h0);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q    <= 2'h0;
            depth_q    <= 4'h0;
            push_count <= 8'h00;
            last_vec   <= 8'h00;
        end else begin
            phase_q <= phase_q + 2'h1;
            // Only the program counter goes on the stack; vector taken with it
            if (pc_push_req) begin
                depth_q    <= depth_q + 4'h1;
                push_count <= push_count + 8'h01;
                last_vec   <= vector_addr;
            end else if (pop_cmd && depth_q != 4'h0) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
module tb;
    import irq_unit_pkg::*;
    typedef struct packed {logic [2:0] src; logic [7:0] vec;} row_t;
    logic        sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_waitrequest, pc_push_req, wake_req, stack_full, sample_phase_pulse;
    logic        ext_irq_pin_b = 1'b1, timer_a_overflow = 1'b0, timer_b_overflow = 1'b0;
    logic        clock_tick = 1'b0, hook_switch_input = 1'b0, hold_input = 1'b1;
    logic        handsfree_input = 1'b0, dialer_on_hook = 1'b0, dialer_hold_line = 1'b0;
    logic [1:0]  operating_mode = 2'h0;
    logic        return_from_irq_instr, plain_return_instr, pop_cmd = 1'b0, pop_from_irq = 1'b0;
    logic [7:0]  vector_addr, push_count, last_vec, n0;
    int          failures = 0, compares = 0, cycles = 0;
    row_t        rows [6] = '{'{3'd0, VEC_EXT}, '{3'd1, VEC_TIMER_A}, '{3'd2, VEC_TIMER_B},
                              '{3'd3, VEC_CLOCK}, '{3'd4, VEC_LINE}, '{3'd5, VEC_LINE}};

    always #5 sys_clk = ~sys_clk;

    phone_mcu_interrupt_unit dut (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_irq_pin_b,
        .timer_a_overflow, .timer_b_overflow, .clock_tick, .hook_switch_input, .hold_input,
        .handsfree_input, .dialer_on_hook, .dialer_hold_line, .operating_mode,
        .sample_phase_pulse, .stack_full, .return_from_irq_instr, .plain_return_instr,
        .pc_push_req, .vector_addr, .wake_req);
    core_model #(.DEPTH(2)) core (.sys_clk, .rst_b, .pc_push_req, .vector_addr, .pop_cmd,
        .pop_from_irq, .sample_phase_pulse, .stack_full, .return_from_irq_instr,
        .plain_return_instr, .push_count, .last_vec);

    // ----------------------------------------------------------------
    // Bus, stimulus and compare tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t value %h, expected %h", $time, got, exp);
        end
    endtask

    // Waits a bounded time for a push; with take low the full wait must stay quiet
    task automatic chk_push(input logic take, input logic [7:0] vec);
        for (int i = 0; i < 40 && push_count === n0; i++) @(negedge sys_clk);
        compares++;
        if (push_count !== n0 + 8'(take) || (take && last_vec !== vec)) begin
            failures++;
            $display("BAD %0t pushes %0d vector %h, expected %h", $time, push_count, last_vec, vec);
        end
        n0 = push_count;
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    // Reads are answered after one wait cycle, so the request sees two edges
    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
        int waits = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(posedge sys_clk);
            waits++;
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        chk_val(32'(waits), 32'h2);
    endtask

    task automatic fire(input logic [2:0] s);
        @(posedge sys_clk);
        case (s)
            3'd0: ext_irq_pin_b <= 1'b0;
            3'd1: timer_a_overflow <= 1'b1;
            3'd2: timer_b_overflow <= 1'b1;
            3'd3: clock_tick <= 1'b1;
            3'd4: hook_switch_input <= ~hook_switch_input;
            default: handsfree_input <= 1'b1;
        endcase
        @(posedge sys_clk);
        {ext_irq_pin_b, timer_a_overflow, timer_b_overflow, clock_tick} <= 4'b1000;
    endtask

    task automatic unwind(input logic from_irq);
        @(posedge sys_clk);
        pop_cmd <= 1'b1;
        pop_from_irq <= from_irq;
        @(posedge sys_clk);
        pop_cmd <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i]) begin
            bus_wr(ADDR_CTRL_PRI, 8'h0F, 4'h1);
            bus_wr(ADDR_CTRL_SEC, 8'h06, 4'h1);
            n0 = push_count;
            fire(rows[i].src);
            chk_push(1'b1, rows[i].vec);
            bus_rd(ADDR_CTRL_PRI, rd);
            chk_val(rd, 32'h0000000E);
            bus_rd(ADDR_CTRL_SEC, rd);
            chk_val(rd, 32'h00000006);
            unwind(1'b1);
            bus_rd(ADDR_CTRL_PRI, rd);
            chk_val(rd, 32'h0000000F);
        end
        // Pending flags with the global enable off, then priority and nesting
        bus_wr(ADDR_CTRL_PRI, 8'h7E, 4'h1);
        chk_push(1'b0, 8'h00);
        chk_val({31'h0, wake_req}, 32'h1);
        bus_rd(ADDR_CTRL_PRI, rd);
        chk_val(rd, 32'h0000007E);
        fire(3'd3);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000026);
        bus_wr(ADDR_CTRL_SEC, 8'h00, 4'h1);
        bus_wr(ADDR_CTRL_PRI, 8'h7F, 4'h1);
        chk_push(1'b1, VEC_EXT);
        bus_wr(ADDR_CTRL_PRI, 8'h6F, 4'h1);
        chk_push(1'b1, VEC_TIMER_A);
        bus_wr(ADDR_CTRL_PRI, 8'h4F, 4'h1);
        chk_push(1'b0, 8'h00);
        unwind(1'b0);
        chk_push(1'b1, VEC_TIMER_B);
        unwind(1'b0);
        bus_rd(ADDR_CTRL_PRI, rd);
        chk_val(rd, 32'h0000000E);
        unwind(1'b1);
        // Fixed-zero, reserved and ignored bus accesses
        bus_wr(ADDR_CTRL_PRI, 8'h80, 4'h1);
        bus_rd(ADDR_CTRL_PRI, rd);
        chk_val(rd, 32'h00000000);
        bus_wr(ADDR_CTRL_SEC, 8'hFF, 4'h1);
        bus_wr(ADDR_CTRL_SEC, 8'h00, 4'h0);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000077);
        bus_wr(10'h3F0, 8'hFF, 4'h1);
        bus_rd(10'h3F0, rd);
        chk_val(rd, 32'h00000000);
        // Hold falls while on-hook and holding, then with the handset lifted
        bus_wr(ADDR_CTRL_SEC, 8'h00, 4'h1);
        dialer_on_hook <= 1'b1;
        dialer_hold_line <= 1'b1;
        @(posedge sys_clk);
        hold_input <= 1'b0;
        repeat (6) @(posedge sys_clk);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000000);
        hold_input <= 1'b1;
        dialer_on_hook <= 1'b0;
        repeat (6) @(posedge sys_clk);
        hold_input <= 1'b0;
        repeat (6) @(posedge sys_clk);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000040);
        bus_wr(ADDR_CTRL_SEC, 8'h00, 4'h1);
        operating_mode <= MODE_IDLE;
        fire(3'd4);
        repeat (6) @(posedge sys_clk);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000000);
        operating_mode <= 2'h0;
        // Second reset in mid-run clears the enables
        bus_wr(ADDR_CTRL_PRI, 8'h0E, 4'h1);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus_rd(ADDR_CTRL_PRI, rd);
        chk_val(rd, 32'h00000000);
        bus_rd(ADDR_CTRL_SEC, rd);
        chk_val(rd, 32'h00000000);
        chk_val({31'h0, wake_req}, 32'h0);
        conclude();
    end
endmodule
